// File: hdl/ths_pkg.sv
`default_nettype none
package ths_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_HITCFG = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_SUM = 8'h0c;
   localparam logic [7:0] ADR_LEVEL = 8'h10;
   localparam logic [7:0] ADR_TOFCNT = 8'h14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_ZC_BIT = 2;
   localparam int ST_ERR_BIT = 3;

   // ------------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------------
   localparam logic [7:0] MIN_START_HIT = 8'h03;
   localparam logic [7:0] RST_START_HIT = 8'h03;
   localparam logic [7:0] RST_STOP_HIT = 8'h08;
   localparam logic [3:0] RST_STEP = 4'h1;
   localparam logic [7:0] RST_FIRST_HIT_LEVEL = 8'h20;
   localparam logic [7:0] RST_ZC_LEVEL = 8'h00;
   localparam int SYNC_STAGES = 2;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FIRST = 2'b01,
      ST_COLLECT = 2'b10
   } ths_state_t;

   typedef struct packed {
      logic [3:0] step;
      logic [7:0] stop_hit;
      logic [7:0] start_hit;
   } ths_cfg_t;

   typedef struct packed {
      logic [7:0] zc_level;
      logic [7:0] first_hit_threshold;
   } ths_level_t;

endpackage
`default_nettype wire

// File: hdl/ths_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ths_edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic rise_o
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ---------------------------------------------------------------
   // Two-stage synchroniser, edge taken only from the second stage
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Rising edge is a one-cycle pulse
   assign rise_o = sync_q & ~prev_q;

endmodule
`default_nettype wire

// File: hdl/ths_time_digitizer.sv
`timescale 1ns/10ps
`default_nettype none
module ths_time_digitizer #(
   parameter int CNT_W = 16,
   parameter int SUM_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic capture_i,
   output logic [SUM_W-1:0] sum_o,
   output logic [7:0] count_o
);

   logic [CNT_W-1:0] time_q;

   // Elaboration check on the accumulator width
   if (SUM_W < CNT_W || SUM_W > 32) begin : g_bad_width
      $error("SUM_W must lie in CNT_W..32");
   end

   // ---------------------------------------------------------------
   // Time base: counts fast oscillator rising edges while running
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         time_q <= '0;
      end else if (run_i && tick_i) begin
         time_q <= time_q + 1'b1;
      end
   end

   // Accumulate the stamp of each evaluated hit
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         sum_o <= '0;
         count_o <= 8'h00;
      end else if (capture_i) begin
         sum_o <= sum_o + SUM_W'(time_q);
         count_o <= count_o + 8'h01;
      end
   end

endmodule
`default_nettype wire

// File: hdl/ths_hit_select.sv
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ths_hit_select (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic cmp_i,
   input wire logic fast_osc_clk_i,
   output logic thr_zc_sel_o,
   output logic [7:0] thr_level_o,
   output logic fast_osc_en_o,
   output logic tof_hit_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ths_pkg::ths_state_t state_q;
   ths_pkg::ths_cfg_t cfg_q;
   ths_pkg::ths_level_t lvl_q;
   logic [7:0] idx_q;
   logic [7:0] idx_d;
   logic [3:0] skip_q;
   logic [3:0] step_m1;
   logic done_q;
   logic err_q;
   logic zc_q;
   logic hit;
   logic tick;
   logic in_range;
   logic eval;
   logic last;
   logic wr;
   logic rd;
   logic start_req;
   logic abort_req;
   logic cfg_ok;
   logic clear;
   logic [31:0] sum;
   logic [7:0] tof_cnt;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   ths_edge_sync u_cmp_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(cmp_i),
      .rise_o(hit)
   );

   ths_edge_sync u_osc_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(fast_osc_clk_i),
      .rise_o(tick)
   );

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Writes land on the edge at which the master sees ack
   assign wr = cyc_i & stb_i & we_i & ack_o;
   assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
   assign start_req = wr && adr_i == ths_pkg::ADR_CTRL && sel_i[0]
      && dat_i[ths_pkg::CTRL_START_BIT];
   assign abort_req = wr && adr_i == ths_pkg::ADR_CTRL && sel_i[0]
      && dat_i[ths_pkg::CTRL_ABORT_BIT];
   // Start hit must be third or later and not past the stop hit
   assign cfg_ok = cfg_q.start_hit >= ths_pkg::MIN_START_HIT
      && cfg_q.stop_hit >= cfg_q.start_hit;
   assign clear = start_req && state_q == ths_pkg::ST_IDLE && cfg_ok;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end

   // Configuration registers, byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= '{step: ths_pkg::RST_STEP, stop_hit: ths_pkg::RST_STOP_HIT,
                    start_hit: ths_pkg::RST_START_HIT};
         lvl_q <= '{zc_level: ths_pkg::RST_ZC_LEVEL,
                    first_hit_threshold: ths_pkg::RST_FIRST_HIT_LEVEL};
      end else if (wr && state_q == ths_pkg::ST_IDLE) begin
         if (adr_i == ths_pkg::ADR_HITCFG) begin
            if (sel_i[0]) cfg_q.start_hit <= dat_i[7:0];
            if (sel_i[1]) cfg_q.stop_hit <= dat_i[15:8];
            if (sel_i[2]) cfg_q.step <= dat_i[19:16];
         end
         if (adr_i == ths_pkg::ADR_LEVEL) begin
            if (sel_i[0]) lvl_q.first_hit_threshold <= dat_i[7:0];
            if (sel_i[1]) lvl_q.zc_level <= dat_i[15:8];
         end
      end
   end

   // Read data, unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd) begin
         unique case (adr_i)
            ths_pkg::ADR_HITCFG: dat_o <= {12'h000, cfg_q};
            ths_pkg::ADR_STATUS: dat_o <= {16'h0000, idx_q, 4'h0, err_q, zc_q,
                                          done_q, state_q != ths_pkg::ST_IDLE};
            ths_pkg::ADR_SUM: dat_o <= sum;
            ths_pkg::ADR_LEVEL: dat_o <= {16'h0000, lvl_q};
            ths_pkg::ADR_TOFCNT: dat_o <= {24'h00_0000, tof_cnt};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Hit selection
   // ---------------------------------------------------------------
   assign idx_d = idx_q + 8'h01;
   assign step_m1 = (cfg_q.step == 4'h0) ? 4'h0 : cfg_q.step - 4'h1;
   assign in_range = idx_d >= cfg_q.start_hit && idx_d <= cfg_q.stop_hit;
   assign last = idx_d == cfg_q.stop_hit;
   // Start and stop always kept; others kept on stride, rest ignored
   assign eval = state_q == ths_pkg::ST_COLLECT && hit && in_range
      && (skip_q == 4'h0 || idx_d == cfg_q.start_hit || last);

   // Measurement sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ths_pkg::ST_IDLE;
      end else if (abort_req) begin
         state_q <= ths_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            ths_pkg::ST_IDLE: begin
               if (clear) begin
                  state_q <= ths_pkg::ST_FIRST;
               end
            end
            ths_pkg::ST_FIRST: begin
               if (hit) begin
                  state_q <= ths_pkg::ST_COLLECT;
               end
            end
            ths_pkg::ST_COLLECT: begin
               if (hit && last) begin
                  state_q <= ths_pkg::ST_IDLE;
               end
            end
            default: state_q <= ths_pkg::ST_IDLE;
         endcase
      end
   end

   // Hit index and stride counter, cleared at burst start
   always_ff @(posedge clk_i) begin
      if (rst_i || clear) begin
         idx_q <= 8'h00;
         skip_q <= 4'h0;
      end else if (state_q == ths_pkg::ST_FIRST && hit) begin
         idx_q <= 8'h01;
      end else if (state_q == ths_pkg::ST_COLLECT && hit) begin
         idx_q <= idx_d;
         if (eval) begin
            skip_q <= step_m1;
         end else if (in_range) begin
            skip_q <= skip_q - 4'h1;
         end
      end
   end

   // Threshold select: raised until first hit, then zero crossing
   always_ff @(posedge clk_i) begin
      if (rst_i || clear) begin
         zc_q <= 1'b0;
      end else if (state_q == ths_pkg::ST_FIRST && hit) begin
         zc_q <= 1'b1;
      end
   end

   // Done and configuration error flags
   always_ff @(posedge clk_i) begin
      if (rst_i || clear) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else if (start_req && !cfg_ok) begin
         err_q <= 1'b1;
      end else if (state_q == ths_pkg::ST_COLLECT && hit && last) begin
         done_q <= 1'b1;
      end
   end

   // Evaluated hit strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tof_hit_o <= 1'b0;
      end else begin
         tof_hit_o <= eval;
      end
   end

   // Fast oscillator powered only while a measurement runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_osc_en_o <= 1'b0;
      end else begin
         fast_osc_en_o <= (state_q != ths_pkg::ST_IDLE || clear) && !abort_req
            && !(state_q == ths_pkg::ST_COLLECT && hit && last);
      end
   end

   // Level handed to the comparator reference
   assign thr_zc_sel_o = zc_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thr_level_o <= ths_pkg::RST_FIRST_HIT_LEVEL;
      end else begin
         thr_level_o <= zc_q ? lvl_q.zc_level : lvl_q.first_hit_threshold;
      end
   end

   // ---------------------------------------------------------------
   // Time digitizer on the fast oscillator
   // ---------------------------------------------------------------
   ths_time_digitizer #(
      .CNT_W(16),
      .SUM_W(32)
   ) u_ths_time_digitizer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(clear),
      .run_i(fast_osc_en_o),
      .tick_i(tick),
      .capture_i(eval),
      .sum_o(sum),
      .count_o(tof_cnt)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   first_raised_a: assert property (state_q == ths_pkg::ST_FIRST |-> !zc_q)
      else $error("zero-cross level used before first hit");
   switch_zc_a: assert property (state_q == ths_pkg::ST_FIRST && hit |=> zc_q)
      else $error("threshold not switched after first hit");
   level_out_a: assert property (zc_q |=> thr_level_o == $past(lvl_q.zc_level))
      else $error("zero-cross level not driven");
   no_first_eval_a: assert property (eval |-> idx_d >= ths_pkg::MIN_START_HIT)
      else $error("hit before third evaluated");
   start_guard_a: assert property (start_req && !cfg_ok
      |=> err_q && state_q == ths_pkg::ST_IDLE)
      else $error("bad start hit accepted");
   stop_end_a: assert property (state_q == ths_pkg::ST_COLLECT && hit && last && !abort_req
      |=> state_q == ths_pkg::ST_IDLE && done_q && !fast_osc_en_o)
      else $error("measurement not ended at stop hit");
   ignore_hits_a: assert property (hit && !in_range |=> !tof_hit_o)
      else $error("ignored hit was evaluated");
   osc_power_a: assert property (state_q == ths_pkg::ST_IDLE && !clear |=> !fast_osc_en_o)
      else $error("oscillator on while idle");
   burst_clear_a: assert property (clear |=> idx_q == 8'h00 && !zc_q && tof_cnt == 8'h00)
      else $error("burst start did not clear");
   bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle");
   eval_strobe_a: assert property (eval |=> tof_hit_o)
      else $error("evaluated hit not strobed");
   osc_start_a: assert property (clear && !abort_req |=> fast_osc_en_o)
      else $error("oscillator not powered at start");

   // ---------------------------------------------------------------
   // Cover properties
   // ---------------------------------------------------------------
   full_meas_c: cover property (clear ##[1:200] done_q);
   stride_skip_c: cover property (state_q == ths_pkg::ST_COLLECT && hit && in_range && !eval);
   first_hit_c: cover property (state_q == ths_pkg::ST_FIRST && hit);
   cfg_err_c: cover property (start_req && !cfg_ok);
   abort_c: cover property (abort_req && state_q == ths_pkg::ST_COLLECT);

endmodule
`default_nettype wire

// File: tb/ths_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------------------------
// Receive comparator and fast oscillator at the block's pins
// -------------------------------------------------------------
module ths_cmp_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [7:0] n_i,
   input wire logic osc_en_i,
   output logic cmp_o,
   output logic osc_o
);
   logic [7:0] left_q;
   logic [2:0] ph_q;
   logic [1:0] div_q;

   // Burst of n wave periods, four cycles high and four low each
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_q <= 8'h00;
         ph_q <= 3'h0;
      end else if (go_i) begin
         left_q <= n_i;
         ph_q <= 3'h0;
      end else if (left_q != 8'h00) begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h7) begin
            left_q <= left_q - 8'h01;
         end
      end
   end

   // Output low between bursts
   assign cmp_o = (left_q != 8'h00) && !ph_q[2];

   // Oscillator runs only while power is requested, else stands low
   always_ff @(posedge clk_i) begin
      if (rst_i || !osc_en_i) begin
         div_q <= 2'h0;
         osc_o <= 1'b0;
      end else begin
         div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
         if (div_q == 2'h2) begin
            osc_o <= ~osc_o;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/test_tof_hit_selection.sv
`timescale 1ns/10ps
`default_nettype none
module test_tof_hit_selection;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic cmp;
   logic osc;
   logic thr_zc_sel_o;
   logic fast_osc_en_o;
   logic tof_hit_o;
   logic [7:0] thr_level_o;
   logic go = 1'b0;
   logic [7:0] n_burst = 8'h00;
   logic [31:0] rd;
   int n_errors = 0;
   int comparisons = 0;
   int n_tof = 0;

   // -------------------------------------------------------------
   // Clock, design and far side
   // -------------------------------------------------------------
   always #2.5 clk_i = ~clk_i;

   ths_hit_select u_ths_hit_select (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .cmp_i(cmp), .fast_osc_clk_i(osc), .thr_zc_sel_o(thr_zc_sel_o),
      .thr_level_o(thr_level_o), .fast_osc_en_o(fast_osc_en_o), .tof_hit_o(tof_hit_o)
   );

   ths_cmp_model u_ths_cmp_model (
      .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(n_burst),
      .osc_en_i(fast_osc_en_o), .cmp_o(cmp), .osc_o(osc)
   );

   // Counts evaluated hit pulses
   always @(posedge clk_i) begin
      if (tof_hit_o === 1'b1) begin
         n_tof <= n_tof + 1;
      end
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // Classic Wishbone cycle, answer taken at the edge that samples ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      i = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && i < 50) begin
         @(posedge clk_i);
         i++;
      end
      if (ack_o !== 1'b1) begin
         n_errors++;
         end_sim;
      end
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // One receive burst of n hits with threshold and count checks
   task burst(input logic [7:0] n, input logic [7:0] first_lvl, input logic [7:0] zc,
              input logic [31:0] exp);
      int i;
      int base;
      base = n_tof;
      // Let the start write and the level register settle
      repeat (2) @(negedge clk_i);
      chk(thr_zc_sel_o, 32'h0, "raised threshold");
      chk(thr_level_o, first_lvl, "first hit level");
      @(posedge clk_i);
      go <= 1'b1;
      n_burst <= n;
      @(posedge clk_i);
      go <= 1'b0;
      i = 0;
      while (cmp !== 1'b1 && i < 20) begin
         @(negedge clk_i);
         i++;
      end
      if (cmp !== 1'b1) begin
         n_errors++;
      end
      repeat (7) @(negedge clk_i);
      chk(thr_zc_sel_o, 32'h1, "zero cross select");
      chk(thr_level_o, zc, "zero cross level");
      repeat (8 * n + 8) @(negedge clk_i);
      chk(n_tof - base, exp, "evaluated hits");
      chk(fast_osc_en_o, 32'h0, "oscillator off");
      wb(1'b0, ths_pkg::ADR_TOFCNT, 32'h0, rd);
      chk(rd, exp, "hit count");
      wb(1'b0, ths_pkg::ADR_STATUS, 32'h0, rd);
      chk(rd & 32'hf, 32'h6, "status done");
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(thr_level_o, ths_pkg::RST_FIRST_HIT_LEVEL, "reset level");
      chk(fast_osc_en_o, 32'h0, "oscillator idle");
      wb(1'b0, ths_pkg::ADR_HITCFG, 32'h0, rd);
      chk(rd, 32'h00010803, "hit cfg reset");
      wb(1'b0, ths_pkg::ADR_LEVEL, 32'h0, rd);
      chk(rd, 32'h00000020, "level reset");
      wb(1'b0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      wb(1'b1, ths_pkg::ADR_LEVEL, 32'h00005a30, rd);
      wb(1'b0, ths_pkg::ADR_LEVEL, 32'h0, rd);
      chk(rd, 32'h00005a30, "level write");
      wb(1'b1, ths_pkg::ADR_CTRL, 32'h1, rd);
      @(negedge clk_i);
      chk(fast_osc_en_o, 32'h1, "oscillator on");
      // Configuration write while busy must be ignored
      wb(1'b1, ths_pkg::ADR_HITCFG, 32'h00010a04, rd);
      burst(8'h0c, 8'h30, 8'h5a, 32'h6);
      wb(1'b0, ths_pkg::ADR_HITCFG, 32'h0, rd);
      chk(rd, 32'h00010803, "cfg locked");
      // Start 4, stop 10, stride 3: hits 4, 7 and 10
      wb(1'b1, ths_pkg::ADR_HITCFG, 32'h00030a04, rd);
      wb(1'b1, ths_pkg::ADR_CTRL, 32'h1, rd);
      burst(8'h0e, 8'h30, 8'h5a, 32'h3);
      // Start hit below three is refused
      wb(1'b1, ths_pkg::ADR_HITCFG, 32'h00010802, rd);
      wb(1'b1, ths_pkg::ADR_CTRL, 32'h1, rd);
      wb(1'b0, ths_pkg::ADR_STATUS, 32'h0, rd);
      chk(rd & 32'h9, 32'h8, "start refused");
      chk(fast_osc_en_o, 32'h0, "oscillator stays off");
      // Abort a running measurement before its first hit
      wb(1'b1, ths_pkg::ADR_HITCFG, 32'h00010803, rd);
      wb(1'b1, ths_pkg::ADR_CTRL, 32'h1, rd);
      @(negedge clk_i);
      chk(fast_osc_en_o, 32'h1, "oscillator on again");
      wb(1'b1, ths_pkg::ADR_CTRL, 32'h2, rd);
      @(negedge clk_i);
      chk(fast_osc_en_o, 32'h0, "oscillator off at abort");
      wb(1'b0, ths_pkg::ADR_STATUS, 32'h0, rd);
      chk(rd & 32'hf, 32'h0, "aborted and cleared");
      end_sim;
   end

   // Hang guard
   initial begin
      #400000;
      n_errors++;
      end_sim;
   end
endmodule
`default_nettype wire
